//--- rtl/fdc_regs_map.vh
// How it works
// - eight offsets decoded; 6 reserved; 4 and 7 split read/write
// - basic mode status reads leave data bus undriven; extended always readable
// - extended status_a: int, drive2_n, step, trk0_n, head, index_n, wp_n, dir
// - legacy status_a: int, drq, step latch, trk0, head_n, index, wp, dir_n
// - legacy step latch sets on step rising, clears on digital input read/reset
// - extended status_b bits 7,6 read one; bit 5 mirrors drive select 0
// - extended status_b bits 3,4 toggle on read/write pulse inactive edges
// - extended status_b bits 0,1 motors, bit 2 write gate
// - legacy status_b bit 2 latches on write gate rising, clears on input read
// - legacy status_b bit 3 latches on read pulse inactive edge
// - legacy status_b bit 4 latches on write pulse inactive edge, ungated
// - legacy status_b shows drive selects 2,3,0,1 low true and drive2_n
// - output register writable anytime, zero on hard reset, kept on soft reset
// - drive select bits binary decoded onto four low-true selects
// - bit 2 low holds controller in soft reset until written one
// - back-to-back 0 then 1 writes give a valid soft reset pulse
// - basic/legacy: dma enable gates dack, tc inputs and drq, irq outputs
// - extended: dma and irq pins always enabled, even in soft reset
// - output bits 4..6 drive motor outputs 0..2 low true
// - output bit 7 drives motor output 3 low true
`ifndef FDC_REGS_MAP_VH
`define FDC_REGS_MAP_VH
`define OFS_STATUS_A  3'h0
`define OFS_STATUS_B  3'h1
`define OFS_DOC       3'h2
`define OFS_TAPE      3'h3
`define OFS_MAIN      3'h4
`define OFS_DATA      3'h5
`define OFS_RSVD      3'h6
`define OFS_DIGIN     3'h7
`define MODE_BASIC    2'h0
`define MODE_EXT      2'h1
`define MODE_LEGACY   2'h2
`define DOC_RESET     8'h00
`define DOC_DMA_BIT   3
`define DOC_RST_BIT   2
`define SOFT_RST_NS   100
`define SOFT_RST_CYC  ((`SOFT_RST_NS + 39) / 40)
`endif

//--- rtl/floppy_status_output_regs.v
`timescale 1ns/1ns
`include "fdc_regs_map.vh"
module floppy_status_output_regs (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [1:0] host_mode,
  input  wire [2:0] addr,
  input  wire       rd_strobe,
  input  wire       wr_strobe,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output reg        rd_data_oe,
  output reg        reg_unsupported,
  input  wire       step_core,
  input  wire       dir_core,
  input  wire       head_core,
  input  wire       write_gate_core,
  input  wire       write_pulse_core,
  input  wire       irq_core,
  input  wire       drq_core,
  input  wire       second_drive_present_n,
  input  wire       track_zero_n,
  input  wire       index_n,
  input  wire       write_protect_n,
  input  wire       read_pulse_n,
  input  wire       dack_n_pin,
  input  wire       tc_pin,
  output reg        dack_n_core,
  output reg        tc_core,
  output reg        irq_out,
  output reg        irq_oe,
  output reg        drq_out,
  output reg        drq_oe,
  output reg        drive_select0_n,
  output reg        drive_select1_n,
  output reg        drive_select2_n,
  output reg        drive_select3_n,
  output reg        motor_on0_n,
  output reg        motor_on1_n,
  output reg        motor_on2_n,
  output reg        motor_on3_n,
  output reg        write_gate_out,
  output reg        soft_reset_q
);
  // pin synchronisers: two stages before any use
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;
  reg       rdp_prev_q;
  reg       wrp_prev_q;
  reg       wg_prev_q;
  reg       step_prev_q;
  reg [7:0] doc_q;
  reg       step_latch_q;
  reg       wg_latch_q;
  reg       rd_latch_q;
  reg       wr_latch_q;
  reg       rd_tog_q;
  reg       wr_tog_q;
  reg [7:0] status_a;
  reg [7:0] status_b;
  reg [7:0] rd_d;
  reg [3:0] ds_n;
  wire      drv2_n  = pin_s2_q[0];
  wire      trk0_n  = pin_s2_q[1];
  wire      idx_n   = pin_s2_q[2];
  wire      wp_n    = pin_s2_q[3];
  wire      rdp_n   = pin_s2_q[4];
  wire      dack_s  = pin_s2_q[5];
  wire      is_ext  = (host_mode == `MODE_EXT);
  wire      is_leg  = (host_mode == `MODE_LEGACY);
  wire      dig_rd  = rd_strobe && (addr == `OFS_DIGIN);
  wire      doc_wr  = wr_strobe && (addr == `OFS_DOC);
  // read pulse inactive edge is its rise (low-true input)
  wire      rdp_end = rdp_n && !rdp_prev_q;
  wire      wrp_end = !write_pulse_core && wrp_prev_q;
  wire      wg_rise = write_gate_core && !wg_prev_q;
  wire      st_rise = step_core && !step_prev_q;
  wire      dma_on  = is_ext || doc_q[`DOC_DMA_BIT];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 6'h3f;
      pin_s2_q <= 6'h3f;
    end else begin
      pin_s1_q <= {dack_n_pin, read_pulse_n, write_protect_n, index_n,
                   track_zero_n, second_drive_present_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // terminal count pin: same two-stage synchroniser as the other pins
  reg       tc_s1_q;
  reg       tc_s2_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tc_s1_q <= 1'b0;
      tc_s2_q <= 1'b0;
    end else begin
      tc_s1_q <= tc_pin;
      tc_s2_q <= tc_s1_q;
    end
  end

  // output register: hard reset only, soft reset leaves it alone
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      doc_q <= `DOC_RESET;
    end else if (doc_wr) begin
      doc_q <= wr_data;
    end
  end

  // edge history
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdp_prev_q  <= 1'b1;
      wrp_prev_q  <= 1'b0;
      wg_prev_q   <= 1'b0;
      step_prev_q <= 1'b0;
    end else begin
      rdp_prev_q  <= rdp_n;
      wrp_prev_q  <= write_pulse_core;
      wg_prev_q   <= write_gate_core;
      step_prev_q <= step_core;
    end
  end

  // latched and toggled status; set beats clear
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_latch_q <= 1'b0;
      wg_latch_q   <= 1'b0;
      rd_latch_q   <= 1'b0;
      wr_latch_q   <= 1'b0;
      rd_tog_q     <= 1'b0;
      wr_tog_q     <= 1'b0;
    end else begin
      if (st_rise)
        step_latch_q <= 1'b1;
      else if (dig_rd || soft_reset_q)
        step_latch_q <= 1'b0;
      if (wg_rise)
        wg_latch_q <= 1'b1;
      else if (dig_rd)
        wg_latch_q <= 1'b0;
      if (rdp_end)
        rd_latch_q <= 1'b1;
      else if (dig_rd)
        rd_latch_q <= 1'b0;
      if (wrp_end)
        wr_latch_q <= 1'b1;
      else if (dig_rd)
        wr_latch_q <= 1'b0;
      if (rdp_end)
        rd_tog_q <= ~rd_tog_q;
      if (wrp_end)
        wr_tog_q <= ~wr_tog_q;
    end
  end

  // drive select decode and status layouts
  always @* begin
    ds_n = 4'hf;
    ds_n[doc_q[1:0]] = 1'b0;
    status_a = 8'h00;
    status_b = 8'h00;
    if (is_leg) begin
      status_a = {irq_core, drq_core, step_latch_q, ~trk0_n, ~head_core,
             ~idx_n, ~wp_n, ~dir_core};
      status_b = {drv2_n, ds_n[1], ds_n[0], wr_latch_q, rd_latch_q,
             wg_latch_q, ds_n[3], ds_n[2]};
    end else begin
      status_a = {irq_core, drv2_n, step_core, trk0_n, head_core,
             idx_n, wp_n, dir_core};
      status_b = {2'b11, doc_q[0], wr_tog_q, rd_tog_q, write_gate_core,
             doc_q[5], doc_q[4]};
    end
    rd_d = 8'h00;
    case (addr)
      `OFS_STATUS_A: rd_d = status_a;
      `OFS_STATUS_B: rd_d = status_b;
      `OFS_DOC:      rd_d = doc_q;
      default:       rd_d = 8'h00;
    endcase
  end

  // host read data and its enable, one cycle after the strobe
  // basic mode keeps the bus undriven for the two status offsets
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data    <= 8'h00;
      rd_data_oe <= 1'b0;
    end else begin
      rd_data    <= rd_d;
      rd_data_oe <= rd_strobe && (addr <= `OFS_DOC) &&
                    !(addr != `OFS_DOC && host_mode == `MODE_BASIC);
    end
  end

  // offsets this block does not serve
  // reserved 6 either way, reads of 3..6, writes of 3..7
  wire      rsvd_hit = (addr == `OFS_RSVD);
  wire      rd_other = rd_strobe && (addr > `OFS_DOC) && (addr != `OFS_DIGIN);
  wire      wr_other = wr_strobe && (addr > `OFS_DOC);

  // unsupported flag: one-cycle pulse per refused access
  // lets the surrounding logic route the access elsewhere
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_unsupported <= 1'b0;
    end else begin
      reg_unsupported <= ((rd_strobe || wr_strobe) && rsvd_hit) ||
                         rd_other || wr_other;
    end
  end

  // drive selects: one low-true output per decoded select value
  // only one can be low, as the decode has a single zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive_select0_n <= 1'b1;
      drive_select1_n <= 1'b1;
      drive_select2_n <= 1'b1;
      drive_select3_n <= 1'b1;
    end else begin
      drive_select0_n <= ds_n[0];
      drive_select1_n <= ds_n[1];
      drive_select2_n <= ds_n[2];
      drive_select3_n <= ds_n[3];
    end
  end

  // motor outputs: low true copies of the four enable bits
  // untouched by soft reset, since the register keeps its bits
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motor_on0_n <= 1'b1;
      motor_on1_n <= 1'b1;
      motor_on2_n <= 1'b1;
      motor_on3_n <= 1'b1;
    end else begin
      motor_on0_n <= ~doc_q[4];
      motor_on1_n <= ~doc_q[5];
      motor_on2_n <= ~doc_q[6];
      motor_on3_n <= ~doc_q[7];
    end
  end

  // core levels passed to the pins through one register
  // keeps every top output straight from a flip-flop
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_gate_out <= 1'b0;
      irq_out        <= 1'b0;
      drq_out        <= 1'b0;
    end else begin
      write_gate_out <= write_gate_core;
      irq_out        <= irq_core;
      drq_out        <= drq_core;
    end
  end

  // request and interrupt drivers: enabled by the dma bit, or always
  // in extended mode, where the bit no longer gates them
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_oe <= 1'b0;
      drq_oe <= 1'b0;
    end else begin
      irq_oe <= dma_on;
      drq_oe <= dma_on;
    end
  end

  // acknowledge and terminal count into the core: forced idle outside extended
  // mode while the dma bit is off, so a floating pin cannot start a transfer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dack_n_core <= 1'b1;
      tc_core     <= 1'b0;
    end else begin
      dack_n_core <= dma_on ? dack_s : 1'b1;
      tc_core     <= dma_on ? tc_s2_q : 1'b0;
    end
  end

  // soft reset: held while bit 2 is low, then stretched by a count
  // so that a one-cycle low from two back-to-back writes still lasts
  // past the minimum width the core needs
  reg [7:0] sr_cnt_q;
  localparam [31:0] SR_HOLD = `SOFT_RST_CYC - 1;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sr_cnt_q     <= 8'h00;
      soft_reset_q <= 1'b1;
    end else begin
      if (!doc_q[`DOC_RST_BIT])
        sr_cnt_q <= SR_HOLD[7:0];
      else if (sr_cnt_q != 8'h00)
        sr_cnt_q <= sr_cnt_q - 8'h01;
      soft_reset_q <= ~doc_q[`DOC_RST_BIT] | (|sr_cnt_q);
    end
  end
endmodule

//--- test/fdc_host.sv
`timescale 1ns/1ns
module fdc_host (
  input  wire       clk,
  output reg  [2:0] addr = 3'h0,
  output reg        rd   = 1'b0,
  output reg        wr   = 1'b0,
  output reg  [7:0] wd   = 8'h00
);
  // one write strobe at a decoded offset
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk) addr <= a;
      wr <= 1'b1;
      wd <= d;
      @(posedge clk) wr <= 1'b0;
    end
  endtask
  // two writes on adjacent edges give a one-cycle low on the soft reset bit
  task wr2(input [7:0] d0, input [7:0] d1);
    begin
      @(posedge clk) addr <= 3'h2;
      wr <= 1'b1;
      wd <= d0;
      @(posedge clk) wd <= d1;
      @(posedge clk) wr <= 1'b0;
    end
  endtask
  // read strobe, then idle while the answer lands
  task rd_reg(input [2:0] a);
    begin
      @(posedge clk) addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

//--- test/fdc_regs_sva.sv
`timescale 1ns/1ns
`include "fdc_regs_map.vh"
module fdc_regs_chk (
  input wire       sys_clk,
  input wire       rst,
  input wire [1:0] host_mode,
  input wire [2:0] addr,
  input wire       rd_strobe,
  input wire       wr_strobe,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire       rd_data_oe,
  input wire       reg_unsupported,
  input wire       irq_oe,
  input wire       drq_oe,
  input wire       drive_select0_n,
  input wire       drive_select1_n,
  input wire       drive_select2_n,
  input wire       drive_select3_n,
  input wire       motor_on0_n,
  input wire       motor_on3_n,
  input wire       soft_reset_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // output register write strobe
  wire doc_wr = wr_strobe && addr == `OFS_DOC;
  chk_basic_hiz: assert property (
    rd_strobe && addr <= 3'h1 && host_mode == `MODE_BASIC |=> !rd_data_oe
  ) else $error("basic status read drove the bus");
  chk_ext_rd_oe: assert property (
    rd_strobe && addr <= 3'h1 && host_mode == `MODE_EXT |=> rd_data_oe
  ) else $error("extended status read not driven");
  chk_srb_ones: assert property (
    rd_strobe && addr == `OFS_STATUS_B && host_mode == `MODE_EXT
    |=> rd_data[7:6] == 2'b11) else $error("status_b top bits not one");
  chk_sel_onehot: assert property (
    $onehot0(~{drive_select3_n, drive_select2_n, drive_select1_n,
               drive_select0_n})) else $error("two drives selected");
  chk_motor0_on: assert property (
    doc_wr |-> ##2 motor_on0_n == !$past(wr_data[4], 2)
  ) else $error("motor 0 output wrong");
  chk_motor3_on: assert property (
    doc_wr |-> ##2 motor_on3_n == !$past(wr_data[7], 2)
  ) else $error("motor 3 output wrong");
  chk_soft_rst: assert property (
    doc_wr && !wr_data[2] |-> ##2 soft_reset_q
  ) else $error("soft reset not entered");
  chk_soft_width: assert property (
    $rose(soft_reset_q) |-> soft_reset_q[*3]
  ) else $error("soft reset pulse too short");
  chk_soft_end: assert property (
    doc_wr && wr_data[2] ##1 (!doc_wr)[*4] |-> !soft_reset_q
  ) else $error("soft reset not released");
  chk_rsvd_flag: assert property (
    (rd_strobe || wr_strobe) && addr == `OFS_RSVD |=> reg_unsupported
  ) else $error("reserved offset not flagged");
  chk_ext_pins_on: assert property (
    host_mode == `MODE_EXT ##1 host_mode == `MODE_EXT |=> irq_oe && drq_oe
  ) else $error("extended mode pins not enabled");
  chk_dma_gated: assert property (
    doc_wr && !wr_data[3] && host_mode == `MODE_BASIC
    ##1 host_mode == `MODE_BASIC |=> !irq_oe && !drq_oe
  ) else $error("dma gate off left pins driven");
  cover property (doc_wr);
  cover property (soft_reset_q ##1 !soft_reset_q);
  cover property (rd_data_oe);
  cover property (reg_unsupported);
endmodule

//--- test/floppy_status_output_regs_tb.sv
`timescale 1ns/1ns
`include "fdc_regs_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module floppy_status_output_regs_tb;
  reg        sys_clk = 1'b0;
  reg        rst = 1'b1;
  reg        read_pulse_n = 1'b1;
  reg  [1:0] host_mode = `MODE_EXT;
  reg  [7:0] pv = 8'h5e;
  reg  [7:0] d;
  reg  [7:0] q[$];
  int        err_total = 0;
  int        cmp_count = 0;
  wire [2:0] addr;
  wire [7:0] wr_data, rd_data;
  wire rd_strobe, wr_strobe, rd_data_oe, reg_unsupported, dack_n_core;
  wire tc_core, irq_out, irq_oe, drq_out, drq_oe, write_gate_out;
  wire drive_select0_n, drive_select1_n, drive_select2_n, drive_select3_n;
  wire motor_on0_n, motor_on1_n, motor_on2_n, motor_on3_n, soft_reset_q;
  wire irq_core, second_drive_present_n, step_core, track_zero_n, head_core;
  wire index_n, write_protect_n, dir_core;
  reg  write_gate_core = 1'b0;
  reg  write_pulse_core = 1'b0;
  wire drq_core = 1'b0;
  reg  dack_n_pin = 1'b1;
  reg  tc_pin = 1'b0;
  // pin vector in extended status_a order
  assign {irq_core, second_drive_present_n, step_core, track_zero_n,
          head_core, index_n, write_protect_n, dir_core} = pv;
  floppy_status_output_regs i_floppy_status_output_regs (.*);
  fdc_host i_fdc_host (.clk(sys_clk), .addr(addr), .rd(rd_strobe),
                       .wr(wr_strobe), .wd(wr_data));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // note the expected byte, then read
  task rd(input [2:0] a, input [7:0] e, input bit x);
    begin
      if (x) q.push_back(e);
      i_fdc_host.rd_reg(a);
    end
  endtask
  task pulse_rd;
    begin
      @(posedge sys_clk) read_pulse_n <= 1'b0;
      @(posedge sys_clk) read_pulse_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task pulse_wr;
    begin
      @(posedge sys_clk) write_gate_core <= 1'b1;
      write_pulse_core <= 1'b1;
      @(posedge sys_clk) write_pulse_core <= 1'b0;
      @(posedge sys_clk) write_gate_core <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  // results are matched against the oldest note
  always @(posedge sys_clk) begin
    if (rd_data_oe === 1'b1 && q.size() > 0) `CHK(rd_data, q.pop_front())
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h833cb925));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`OFS_STATUS_B, 8'hc0, 1);
    rd(`OFS_DOC, `DOC_RESET, 1);
    $display("test done: reset values");
    repeat (4) begin
      @(posedge sys_clk) pv <= 8'($urandom);
      repeat (4) @(posedge sys_clk);
      rd(`OFS_STATUS_A, pv, 1);
    end
    $display("test done: extended status_a");
    i_fdc_host.wr_reg(`OFS_DOC, 8'h1c);
    rd(`OFS_STATUS_B, 8'hc1, 1);
    `CHK({drive_select0_n, drive_select1_n, motor_on0_n}, 3'b010)
    i_fdc_host.wr_reg(`OFS_DOC, 8'h2d);
    pulse_rd;
    pulse_wr;
    @(posedge sys_clk) write_gate_core <= 1'b1;
    rd(`OFS_STATUS_B, 8'hfe, 1);
    write_gate_core <= 1'b0;
    $display("test done: extended status_b");
    repeat (6) begin
      d = 8'($urandom) | 8'h04;
      i_fdc_host.wr_reg(`OFS_DOC, d);
      rd(`OFS_DOC, d, 1);
      `CHK({motor_on3_n, motor_on2_n, motor_on1_n, motor_on0_n}, ~d[7:4])
    end
    i_fdc_host.wr2(8'h18, 8'h1c);
    rd(`OFS_DOC, 8'h1c, 1);
    `CHK(soft_reset_q, 1'b0)
    $display("test done: output register");
    @(posedge sys_clk) host_mode <= `MODE_BASIC;
    pv <= 8'hde;
    dack_n_pin <= 1'b0;
    tc_pin <= 1'b1;
    i_fdc_host.wr_reg(`OFS_DOC, 8'h0c);
    repeat (2) @(posedge sys_clk);
    `CHK({irq_oe, irq_out}, 2'b11)
    `CHK({dack_n_core, tc_core}, 2'b01)
    i_fdc_host.wr_reg(`OFS_DOC, 8'h04);
    repeat (2) @(posedge sys_clk);
    `CHK({irq_oe, drq_oe}, 2'b00)
    `CHK({dack_n_core, tc_core}, 2'b10)
    rd(`OFS_STATUS_A, 8'h00, 0);
    $display("test done: basic mode");
    @(posedge sys_clk) host_mode <= `MODE_LEGACY;
    pv <= 8'h5e;
    rd(`OFS_DIGIN, 8'h00, 0);
    rd(`OFS_STATUS_B, 8'hc3, 1);
    pulse_rd;
    rd(`OFS_STATUS_B, 8'hcb, 1);
    @(posedge sys_clk) pv <= 8'h7e;
    rd(`OFS_STATUS_A, 8'h21, 1);
    @(posedge sys_clk) pv <= 8'h5e;
    rd(`OFS_DIGIN, 8'h00, 0);
    rd(`OFS_STATUS_A, 8'h01, 1);
    rd(`OFS_STATUS_B, 8'hc3, 1);
    pulse_wr;
    rd(`OFS_STATUS_B, 8'hd7, 1);
    rd(`OFS_RSVD, 8'h00, 0);
    $display("test done: legacy mode");
    `CHK(q.size(), 0)
    complete_run;
  end
endmodule
bind floppy_status_output_regs fdc_regs_chk i_fdc_regs_chk (.*);
